// ### verilog/asu_defs.svh
// constants for the asynchronous serial uart core
`ifndef ASU_DEFS_SVH
`define ASU_DEFS_SVH
`define ASU_ADDR_MODE 16'hFF70
`define ASU_ADDR_BAUD 16'hFF71
`define ASU_ADDR_DATA 16'hFF72
`define ASU_ADDR_ERR 16'hFF73
`define ASU_MODE_RST 8'h01
`define ASU_BAUD_RST 8'h1F
`define ASU_BAUD_MASK 8'hDF
`define ASU_BUF_RST 8'hFF
`define ASU_ERR_RST 3'h0
`define ASU_READ_NONE 8'h00
`define ASU_MODE_POWER 7
`define ASU_MODE_TXE 6
`define ASU_MODE_RXE 5
`define ASU_MODE_PS_HI 4
`define ASU_MODE_PS_LO 3
`define ASU_MODE_CL 2
`define ASU_MODE_SL 1
`define ASU_MODE_FIXED 0
`define ASU_BAUD_SEL_HI 7
`define ASU_BAUD_SEL_LO 6
`define ASU_BAUD_DIV_HI 4
`define ASU_BAUD_DIV_LO 0
`define ASU_ERR_PE 2
`define ASU_ERR_FE 1
`define ASU_ERR_OVE 0
`define ASU_PRE_DIV2 5'h01
`define ASU_PRE_DIV8 5'h07
`define ASU_PRE_DIV32 5'h1F
`define ASU_DIV_MIN 5'h08
`define ASU_LAST_BIT8 3'h7
`define ASU_LAST_BIT7 3'h6
`define ASU_SYS_CLK_KHZ 50000
`define ASU_MAX_KBPS 625
`define ASU_MIN_BIT_CYC ((`ASU_SYS_CLK_KHZ + `ASU_MAX_KBPS - 1) / `ASU_MAX_KBPS)
`endif

// ### verilog/asu_pkg.sv
// types shared by the asynchronous serial uart core
package asu_pkg;
    typedef enum logic [1:0] {
        ASU_PAR_NONE = 2'b00,
        ASU_PAR_ZERO = 2'b01,
        ASU_PAR_ODD = 2'b10,
        ASU_PAR_EVEN = 2'b11
    } asu_parity_t;
    typedef enum logic [1:0] {
        ASU_BASE_TIMER = 2'b00,
        ASU_BASE_DIV2 = 2'b01,
        ASU_BASE_DIV8 = 2'b10,
        ASU_BASE_DIV32 = 2'b11
    } asu_base_t;
    typedef enum logic [2:0] {
        ASU_ST_IDLE = 3'b000,
        ASU_ST_START = 3'b001,
        ASU_ST_DATA = 3'b010,
        ASU_ST_PAR = 3'b011,
        ASU_ST_STOP = 3'b100
    } asu_state_t;
endpackage : asu_pkg

// ### verilog/asu_baud_if.sv
// link between the uart core and its baud generator
`timescale 1ns/1ps
interface asu_baud_if;
    logic power;
    asu_pkg::asu_base_t base_sel;
    logic [4:0] divisor;
    logic timer_level;
    logic tx_run;
    logic rx_restart;
    logic base_tick;
    logic tx_half;
    logic rx_half;
    modport core (
        output power, base_sel, divisor, timer_level, tx_run, rx_restart,
        input base_tick, tx_half, rx_half
    );
    modport gen (
        input power, base_sel, divisor, timer_level, tx_run, rx_restart,
        output base_tick, tx_half, rx_half
    );
endinterface : asu_baud_if

// ### verilog/asu_baud.sv
// baud generator: base clock select and 5-bit division counters
`timescale 1ns/1ps
`include "asu_defs.svh"
module asu_baud #(
    parameter int DIV_W = 5
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    asu_baud_if.gen bif
);
    // the divisor field is five bits wide
    generate
        if (DIV_W < 5) begin : g_bad_width
            $error("asu_baud: DIV_W must be at least 5");
        end
    endgenerate

    logic [4:0] pre_q;
    logic [4:0] pre_last;
    logic timer_d1_q;
    logic base_tick;
    logic [DIV_W-1:0] k_val;
    logic [DIV_W-1:0] tx_cnt_q;
    logic [DIV_W-1:0] rx_cnt_q;

    // terminal count of a division counter
    function automatic logic asu_is_last(input logic [DIV_W-1:0] cnt,
                                         input logic [DIV_W-1:0] k);
        asu_is_last = (cnt == (k - {{(DIV_W-1){1'b0}}, 1'b1}));
    endfunction : asu_is_last

    // prohibited divisors below eight run as eight
    assign k_val = (bif.divisor < `ASU_DIV_MIN) ? DIV_W'(`ASU_DIV_MIN) : DIV_W'(bif.divisor);

    // prescaler end count per base select
    always_comb begin
        case (bif.base_sel)
            asu_pkg::ASU_BASE_DIV2: pre_last = `ASU_PRE_DIV2;
            asu_pkg::ASU_BASE_DIV8: pre_last = `ASU_PRE_DIV8;
            default: pre_last = `ASU_PRE_DIV32;
        endcase
    end

    // prescaler, held while power is off so the base clock stands still
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !bif.power || pre_q == pre_last) begin
            pre_q <= 5'h00;
        end else begin
            pre_q <= pre_q + 5'h01;
        end
    end

    // timer level delay for rising edge detection
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_d1_q <= 1'b0;
        end else begin
            timer_d1_q <= bif.timer_level;
        end
    end

    // base clock pulse; none while power is off
    always_comb begin
        if (!bif.power) begin
            base_tick = 1'b0;
        end else if (bif.base_sel == asu_pkg::ASU_BASE_TIMER) begin
            base_tick = bif.timer_level & ~timer_d1_q;
        end else begin
            base_tick = (pre_q == pre_last);
        end
    end
    assign bif.base_tick = base_tick;

    // transmit division counter, free while a frame is sent
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !bif.tx_run) begin
            tx_cnt_q <= '0;
        end else if (base_tick) begin
            tx_cnt_q <= asu_is_last(tx_cnt_q, k_val) ? '0 : tx_cnt_q + 1'b1;
        end
    end

    // receive division counter, restarted at the start edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || bif.rx_restart) begin
            rx_cnt_q <= '0;
        end else if (base_tick) begin
            rx_cnt_q <= asu_is_last(rx_cnt_q, k_val) ? '0 : rx_cnt_q + 1'b1;
        end
    end

    // half-bit pulses: bit rate is the counter output halved
    assign bif.tx_half = bif.tx_run & base_tick & asu_is_last(tx_cnt_q, k_val);
    assign bif.rx_half = ~bif.rx_restart & base_tick & asu_is_last(rx_cnt_q, k_val);
endmodule : asu_baud

// ### verilog/asu_core.sv
// asynchronous serial uart core with mode, baud, error and data registers
`timescale 1ns/1ps
`include "asu_defs.svh"
module asu_core #(
    parameter int DIV_W = 5
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] rd_data_o,
    input wire logic serial_in_pin_i,
    input wire logic timer_clk_i,
    output logic serial_out_pin_o,
    output logic transmit_done_irq_o,
    output logic rx_done_o,
    output logic rx_error_o
);
    asu_baud_if bif ();

    logic [7:0] mode_q;
    logic [7:0] baud_q;
    logic [2:0] err_q;
    logic [7:0] rxb_q;
    logic full_q;
    logic rxd_m_q;
    logic rxd_s_q;
    logic tmr_m_q;
    logic tmr_s_q;
    logic rxd;
    logic power;
    logic txe_s_q;
    logic rxe_s_q;
    logic len8;
    logic [1:0] par_mode;
    logic wr_mode;
    logic wr_baud;
    logic wr_tx;
    logic rd_err;
    logic rd_buf;
    asu_pkg::asu_state_t tx_st_q;
    logic [7:0] txs_q;
    logic [2:0] tx_bit_q;
    logic tx_phase_q;
    logic tx_par_q;
    logic tx_stop2_q;
    logic tx_end;
    asu_pkg::asu_state_t rx_st_q;
    logic [7:0] rxs_q;
    logic [2:0] rx_bit_q;
    logic rx_phase_q;
    logic rx_par_q;
    logic rx_smp;
    logic rx_fin;
    logic [7:0] rx_data;
    logic pe_new;
    logic fe_new;
    logic ov_new;

    // data bits that belong to the character
    function automatic logic [7:0] asu_mask(input logic [7:0] d, input logic l8);
        asu_mask = l8 ? d : {1'b0, d[6:0]};
    endfunction : asu_mask

    // parity bit for a character in the given mode
    function automatic logic asu_par(input logic [7:0] d, input logic l8,
                                     input logic [1:0] ps);
        case (asu_pkg::asu_parity_t'(ps))
            asu_pkg::ASU_PAR_ODD: asu_par = ~(^asu_mask(d, l8));
            asu_pkg::ASU_PAR_EVEN: asu_par = ^asu_mask(d, l8);
            default: asu_par = 1'b0;
        endcase
    endfunction : asu_par

    // last data bit index for the character length
    function automatic logic [2:0] asu_last(input logic l8);
        asu_last = l8 ? `ASU_LAST_BIT8 : `ASU_LAST_BIT7;
    endfunction : asu_last

    // control fields
    assign power = mode_q[`ASU_MODE_POWER];
    assign len8 = mode_q[`ASU_MODE_CL];
    assign par_mode = mode_q[`ASU_MODE_PS_HI:`ASU_MODE_PS_LO];
    assign rxd = power ? rxd_s_q : 1'b1;

    // access decode
    assign wr_mode = wr_i && (addr_i == `ASU_ADDR_MODE);
    assign wr_baud = wr_i && (addr_i == `ASU_ADDR_BAUD);
    assign wr_tx = wr_i && (addr_i == `ASU_ADDR_DATA) && txe_s_q
                   && (tx_st_q == asu_pkg::ASU_ST_IDLE);
    assign rd_err = rd_i && (addr_i == `ASU_ADDR_ERR);
    assign rd_buf = rd_i && (addr_i == `ASU_ADDR_DATA);

    // baud generator hookup
    assign bif.power = power;
    assign bif.base_sel = asu_pkg::asu_base_t'(baud_q[`ASU_BAUD_SEL_HI:`ASU_BAUD_SEL_LO]);
    assign bif.divisor = baud_q[`ASU_BAUD_DIV_HI:`ASU_BAUD_DIV_LO];
    assign bif.timer_level = tmr_s_q;
    assign bif.tx_run = (tx_st_q != asu_pkg::ASU_ST_IDLE);
    assign bif.rx_restart = (rx_st_q == asu_pkg::ASU_ST_IDLE) || (rx_st_q == asu_pkg::ASU_ST_START
                            && !rxe_s_q);

    asu_baud #(
        .DIV_W(DIV_W)
    ) u_baud (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .bif(bif.gen)
    );

    // pin synchronisers for serial input and timer clock
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rxd_m_q <= 1'b1;
            rxd_s_q <= 1'b1;
            tmr_m_q <= 1'b0;
            tmr_s_q <= 1'b0;
        end else begin
            rxd_m_q <= serial_in_pin_i;
            rxd_s_q <= rxd_m_q;
            tmr_m_q <= timer_clk_i;
            tmr_s_q <= tmr_m_q;
        end
    end

    // mode register, bit 0 always reads one
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_q <= `ASU_MODE_RST;
        end else if (wr_mode) begin
            mode_q <= wr_data_i | `ASU_MODE_RST;
        end
    end

    // baud control register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            baud_q <= `ASU_BAUD_RST;
        end else if (wr_baud) begin
            baud_q <= wr_data_i & `ASU_BAUD_MASK;
        end
    end

    // enables taken over on base clock, dropped at once by power off
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !power) begin
            txe_s_q <= 1'b0;
            rxe_s_q <= 1'b0;
        end else if (bif.base_tick) begin
            txe_s_q <= mode_q[`ASU_MODE_TXE];
            rxe_s_q <= mode_q[`ASU_MODE_RXE];
        end
    end

    // transmit bit ends every second half-bit pulse
    assign tx_end = bif.tx_half & tx_phase_q;

    // transmit sequencer and shift register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !txe_s_q) begin
            tx_st_q <= asu_pkg::ASU_ST_IDLE;
            txs_q <= `ASU_BUF_RST;
            serial_out_pin_o <= 1'b1;
            tx_bit_q <= 3'h0;
            tx_phase_q <= 1'b0;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
            transmit_done_irq_o <= 1'b0;
        end else begin
            transmit_done_irq_o <= 1'b0;
            if (bif.tx_half) begin
                tx_phase_q <= ~tx_phase_q;
            end
            case (tx_st_q)
                asu_pkg::ASU_ST_IDLE: begin
                    tx_phase_q <= 1'b0;
                    if (wr_tx) begin
                        txs_q <= wr_data_i;
                        tx_par_q <= asu_par(wr_data_i, len8, par_mode);
                        serial_out_pin_o <= 1'b0;
                        tx_st_q <= asu_pkg::ASU_ST_START;
                    end
                end
                asu_pkg::ASU_ST_START: begin
                    if (tx_end) begin
                        serial_out_pin_o <= txs_q[0];
                        txs_q <= {1'b1, txs_q[7:1]};
                        tx_bit_q <= 3'h0;
                        tx_st_q <= asu_pkg::ASU_ST_DATA;
                    end
                end
                asu_pkg::ASU_ST_DATA: begin
                    if (tx_end) begin
                        if (tx_bit_q != asu_last(len8)) begin
                            serial_out_pin_o <= txs_q[0];
                            txs_q <= {1'b1, txs_q[7:1]};
                            tx_bit_q <= tx_bit_q + 3'h1;
                        end else if (par_mode == asu_pkg::ASU_PAR_NONE) begin
                            serial_out_pin_o <= 1'b1;
                            tx_stop2_q <= mode_q[`ASU_MODE_SL];
                            tx_st_q <= asu_pkg::ASU_ST_STOP;
                        end else begin
                            serial_out_pin_o <= tx_par_q;
                            tx_st_q <= asu_pkg::ASU_ST_PAR;
                        end
                    end
                end
                asu_pkg::ASU_ST_PAR: begin
                    if (tx_end) begin
                        serial_out_pin_o <= 1'b1;
                        tx_stop2_q <= mode_q[`ASU_MODE_SL];
                        tx_st_q <= asu_pkg::ASU_ST_STOP;
                    end
                end
                asu_pkg::ASU_ST_STOP: begin
                    if (tx_end) begin
                        if (tx_stop2_q) begin
                            tx_stop2_q <= 1'b0;
                        end else begin
                            txs_q <= `ASU_BUF_RST;
                            transmit_done_irq_o <= 1'b1;
                            tx_st_q <= asu_pkg::ASU_ST_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_q <= asu_pkg::ASU_ST_IDLE;
                end
            endcase
        end
    end

    // receive samples at bit centres after the start centre
    assign rx_smp = bif.rx_half & rx_phase_q;
    assign rx_fin = rx_smp && (rx_st_q == asu_pkg::ASU_ST_STOP);
    assign rx_data = len8 ? rxs_q : {1'b0, rxs_q[7:1]};
    assign fe_new = rx_fin & ~rxd;
    assign pe_new = rx_fin && par_mode[1]
                    && (rx_par_q != asu_par(rx_data, len8, par_mode));
    assign ov_new = rx_fin & full_q;

    // receive sequencer and shift register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !rxe_s_q) begin
            rx_st_q <= asu_pkg::ASU_ST_IDLE;
            rxs_q <= 8'h00;
            rx_bit_q <= 3'h0;
            rx_phase_q <= 1'b0;
            rx_par_q <= 1'b0;
        end else begin
            if (bif.rx_half) begin
                rx_phase_q <= ~rx_phase_q;
            end
            case (rx_st_q)
                asu_pkg::ASU_ST_IDLE: begin
                    rx_phase_q <= 1'b0;
                    if (!rxd) begin
                        rx_st_q <= asu_pkg::ASU_ST_START;
                    end
                end
                asu_pkg::ASU_ST_START: begin
                    if (bif.rx_half) begin
                        rx_phase_q <= 1'b0;
                        rx_bit_q <= 3'h0;
                        rx_st_q <= rxd ? asu_pkg::ASU_ST_IDLE : asu_pkg::ASU_ST_DATA;
                    end
                end
                asu_pkg::ASU_ST_DATA: begin
                    if (rx_smp) begin
                        rxs_q <= {rxd, rxs_q[7:1]};
                        if (rx_bit_q != asu_last(len8)) begin
                            rx_bit_q <= rx_bit_q + 3'h1;
                        end else if (par_mode == asu_pkg::ASU_PAR_NONE) begin
                            rx_st_q <= asu_pkg::ASU_ST_STOP;
                        end else begin
                            rx_st_q <= asu_pkg::ASU_ST_PAR;
                        end
                    end
                end
                asu_pkg::ASU_ST_PAR: begin
                    if (rx_smp) begin
                        rx_par_q <= rxd;
                        rx_st_q <= asu_pkg::ASU_ST_STOP;
                    end
                end
                asu_pkg::ASU_ST_STOP: begin
                    if (rx_smp) begin
                        rx_st_q <= asu_pkg::ASU_ST_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= asu_pkg::ASU_ST_IDLE;
                end
            endcase
        end
    end

    // receive buffer and its unread flag; a new byte is only taken while the buffer is empty
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !power) begin
            rxb_q <= `ASU_BUF_RST;
            full_q <= 1'b0;
        end else if (rx_fin && !full_q) begin
            rxb_q <= rx_data;
            full_q <= 1'b1;
        end else if (rd_buf) begin
            full_q <= 1'b0;
        end
    end

    // error flags; a new error wins over the read clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !power || !mode_q[`ASU_MODE_RXE]) begin
            err_q <= `ASU_ERR_RST;
        end else if (rx_fin) begin
            err_q[`ASU_ERR_PE] <= pe_new | (err_q[`ASU_ERR_PE] & ~rd_err);
            err_q[`ASU_ERR_FE] <= fe_new | (err_q[`ASU_ERR_FE] & ~rd_err);
            err_q[`ASU_ERR_OVE] <= ov_new | (err_q[`ASU_ERR_OVE] & ~rd_err);
        end else if (rd_err) begin
            err_q <= `ASU_ERR_RST;
        end
    end

    // receive event pulses
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_done_o <= 1'b0;
            rx_error_o <= 1'b0;
        end else begin
            rx_done_o <= rx_fin & ~full_q;
            rx_error_o <= pe_new | fe_new | ov_new;
        end
    end

    // read data; transmit register reads nothing back
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_data_o <= `ASU_READ_NONE;
        end else if (rd_i) begin
            if (addr_i == `ASU_ADDR_MODE) begin
                rd_data_o <= mode_q;
            end else if (addr_i == `ASU_ADDR_BAUD) begin
                rd_data_o <= baud_q;
            end else if (addr_i == `ASU_ADDR_DATA) begin
                rd_data_o <= rxb_q;
            end else if (addr_i == `ASU_ADDR_ERR) begin
                rd_data_o <= {5'h00, err_q};
            end else begin
                rd_data_o <= `ASU_READ_NONE;
            end
        end
    end
endmodule : asu_core

// ### bench/asu_properties.sv
// port checker for the uart core
`timescale 1ns/1ps
module asu_properties (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_data_o,
    input wire logic serial_in_pin_i,
    input wire logic timer_clk_i,
    input wire logic serial_out_pin_o,
    input wire logic transmit_done_irq_o,
    input wire logic rx_done_o,
    input wire logic rx_error_o
);
    logic pw_q;
    logic txe_q;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // shadow of the power and transmit enables
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pw_q <= 1'h0;
            txe_q <= 1'h0;
        end else if (wr_i && addr_i == 16'hFF70) begin
            pw_q <= wr_data_i[7];
            txe_q <= wr_data_i[7] & wr_data_i[6];
        end
    end
    AST_RST_IDLE: assert property ($fell(rst_i) |-> serial_out_pin_o && rd_data_o == 8'h00)
        else $error("line or read data wrong after reset");
    AST_MODE_BIT0: assert property (rd_i && addr_i == 16'hFF70 |=> rd_data_o[0])
        else $error("mode bit 0 read as zero");
    AST_ERR_UPPER: assert property (rd_i && addr_i == 16'hFF73 |=> rd_data_o[7:3] == 5'h00)
        else $error("error status upper bits set");
    AST_OFF_BUF: assert property (!pw_q && rd_i && addr_i == 16'hFF72 |=> rd_data_o == 8'hFF)
        else $error("buffer not all ones while powered off");
    AST_OFF_QUIET: assert property (!pw_q |-> serial_out_pin_o && !rx_done_o)
        else $error("activity while powered off");
    AST_TX_REFUSED: assert property (!txe_q && wr_i && addr_i == 16'hFF72 |=> serial_out_pin_o [*8])
        else $error("transmit started while disabled");
    AST_START_LEN: assert property ($fell(serial_out_pin_o) |-> !serial_out_pin_o [*8])
        else $error("start bit too short");
    AST_DONE_PULSE: assert property (transmit_done_irq_o |=> !transmit_done_irq_o)
        else $error("transmit done longer than one cycle");
    AST_DONE_IDLE: assert property (transmit_done_irq_o |-> serial_out_pin_o && $past(serial_out_pin_o, 8))
        else $error("transmit done without stop level");
    AST_RX_PULSE: assert property (rx_done_o |=> !rx_done_o)
        else $error("receive done longer than one cycle");
endmodule : asu_properties
bind asu_core asu_properties i_props (.sys_clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wr_data_i,
    .rd_data_o, .serial_in_pin_i, .timer_clk_i, .serial_out_pin_o, .transmit_done_irq_o,
    .rx_done_o, .rx_error_o);

// ### bench/asu_remote.sv
// remote serial partner: frame capture and frame sender
`timescale 1ns/1ps
module asu_remote #(
    parameter int BIT = 128
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    int nframe = 10;
    logic [11:0] cap;
    event frame_ev;
    initial line_o = 1'h1;
    // sample each bit of a device frame at its centre
    always begin
        @(negedge line_i);
        cap = 12'hFFF;
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < nframe; i++) begin
            cap[i] = line_i;
            if (i < nframe - 1) repeat (BIT) @(posedge clk_i);
        end
        -> frame_ev;
    end
    // send a frame lsb first, then one idle bit
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_i);
            #1;
            line_o = (i < n) ? f[i] : 1'h1;
            repeat (BIT - 1) @(posedge clk_i);
        end
    endtask : send
endmodule : asu_remote

// ### bench/testbench.sv
// self-checking bench for the uart core
`timescale 1ns/1ps
module testbench;
    localparam int BIT = 128;
    logic sys_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic rd_pend = 1'h0;
    logic tclk = 1'h0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wr_data_i = 8'h00;
    logic [7:0] rd_data_o;
    logic [7:0] mode = 8'h01;
    logic [7:0] d;
    logic sin, sout, txd, rxd, rxe;
    int miscompares = 0;
    int tests_run = 0;
    int len;
    logic [7:0] qr[$];
    logic [11:0] qf[$];
    asu_core i_dut (.sys_clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wr_data_i, .rd_data_o,
        .serial_in_pin_i(sin), .timer_clk_i(tclk), .serial_out_pin_o(sout),
        .transmit_done_irq_o(txd), .rx_done_o(rxd), .rx_error_o(rxe));
    asu_remote #(.BIT(BIT)) i_remote (.clk_i(sys_clk_i), .line_i(sout), .line_o(sin));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    always #170 tclk = ~tclk;
    task automatic cmp(input logic [11:0] g, input logic [11:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
        cmp({4'h0, g}, {4'h0, e});
    endtask : cmp_rd
    // one register access; a read notes its expected data
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        #1;
        {wr_i, rd_i} = {w, !w};
        addr_i = a;
        wr_data_i = v;
        if (!w) qr.push_back(v);
        @(posedge sys_clk_i);
        #1;
        {wr_i, rd_i} = 2'h0;
    endtask : bus
    // expected line frame, bit 0 is the start bit
    function automatic logic [11:0] frame(input logic [7:0] v, input logic [7:0] m,
        output int n);
        logic [7:0] x;
        frame = 12'hFFE;
        x = m[2] ? v : {1'h0, v[6:0]};
        n = m[2] ? 9 : 8;
        for (int i = 0; i < n - 1; i++) frame[i + 1] = x[i];
        if (m[4:3] != 2'h0) begin
            frame[n] = m[4] & ~(m[3] ^ (^x));
            n++;
        end
        n = n + 1 + int'(m[1]);
    endfunction : frame
    // wait for the masked pulses, then collect a few more cycles
    task automatic wait_evt(input logic [2:0] m, output logic [2:0] s);
        s = 3'h0;
        for (int i = 0; i < 3000 && s == 3'h0; i++) begin
            @(posedge sys_clk_i);
            s = {rxe, rxd, txd} & m;
        end
        repeat (3) begin
            @(posedge sys_clk_i);
            s |= {rxe, rxd, txd} & m;
        end
    endtask : wait_evt
    task automatic cfg(input logic [1:0] p, input logic cl, input logic sl);
        bus(1, 16'hFF70, mode & 8'h9F);
        repeat (16) @(posedge sys_clk_i);
        mode = {3'h4, p, cl, sl, 1'h1};
        bus(1, 16'hFF70, mode);
        repeat (8) @(posedge sys_clk_i);
        mode[6:5] = 2'h3;
        bus(1, 16'hFF70, mode);
        repeat (8) @(posedge sys_clk_i);
    endtask : cfg
    task automatic tx(input logic [7:0] v);
        logic [2:0] s;
        qf.push_back(frame(v, mode, len));
        i_remote.nframe = len;
        bus(1, 16'hFF72, v);
        bus(1, 16'hFF72, ~v);
        wait_evt(3'h1, s);
        cmp(12'(s[0]), 12'h001);
    endtask : tx
    task automatic rx(input logic [7:0] v, input int bad, input logic [2:0] err,
        input logic [8:0] rb);
        logic [2:0] s;
        logic [11:0] f;
        f = frame(v, mode, len);
        if (bad != 0) f[len - 3 + bad - int'(mode[1])] ^= 1'h1;
        fork
            i_remote.send(f, len);
            wait_evt(3'h6, s);
        join
        cmp(12'(s[2]), 12'(err != 3'h0));
        cmp(12'(s[1]), 12'(err != 3'h1));
        if (rb[8] && err != 3'h0) bus(0, 16'hFF73, {5'h00, err});
        if (rb[8]) bus(0, 16'hFF72, rb[7:0]);
    endtask : rx
    task automatic print_verdict();
        miscompares += qf.size() + qr.size();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // compare each read one cycle after its strobe
    always @(posedge sys_clk_i) begin
        if (rd_pend) cmp_rd(rd_data_o, qr.size() ? qr.pop_front() : 8'hXX);
        rd_pend <= rd_i;
    end
    // compare each captured frame with the oldest note
    always @(i_remote.frame_ev) begin
        cmp(i_remote.cap, qf.size() ? qf.pop_front() : 12'hXXX);
    end
    initial begin
        #1_500_000;
        miscompares++;
        print_verdict();
    end
    initial begin
        d = 8'($urandom(32'h36a12846));
        repeat (6) @(posedge sys_clk_i);
        #1;
        rst_i = 1'h0;
        bus(0, 16'hFF70, 8'h01);
        bus(0, 16'hFF71, 8'h1F);
        bus(0, 16'hFF72, 8'hFF);
        bus(0, 16'hFF73, 8'h00);
        bus(0, 16'hFF7F, 8'h00);
        bus(1, 16'hFF72, 8'h5A);
        $display("test reset finished");
        bus(1, 16'hFF71, 8'h88);
        bus(0, 16'hFF71, 8'h88);
        for (int i = 0; i < 8; i++) begin
            cfg(i[2:1], i[0], i[1]);
            tx(8'($urandom));
            d = 8'($urandom);
            rx(d, 0, 3'h0, {1'h1, d & {i[0], 7'h7F}});
        end
        $display("test formats finished");
        cfg(2'h2, 1'h1, 1'h0);
        rx(d, 1, 3'h4, {1'h1, d});
        bus(0, 16'hFF73, 8'h00);
        cfg(2'h1, 1'h0, 1'h1);
        rx(d, 1, 3'h0, {2'h2, d[6:0]});
        $display("test parity finished");
        cfg(2'h0, 1'h1, 1'h0);
        rx(d, 0, 3'h0, 9'h000);
        rx(~d, 0, 3'h1, {1'h1, d});
        rx(d, 2, 3'h2, 9'h000);
        $display("test errors finished");
        bus(1, 16'hFF70, 8'h81);
        bus(1, 16'hFF70, 8'h01);
        bus(0, 16'hFF72, 8'hFF);
        bus(0, 16'hFF73, 8'h00);
        bus(1, 16'hFF72, 8'h3C);
        repeat (2 * BIT) @(posedge sys_clk_i);
        $display("test power off finished");
        print_verdict();
    end
endmodule : testbench
